// File: smm_port.sv
// serial management bus slave port with voltage reading and limit registers
//
// Functional notes
// - answer only to fixed seven-bit address 0x2E.
// - address byte is address then direction bit; 0x5C writes.
// - each byte is eight bits msb first plus one acknowledge clock.
// - data changes only while clock low; rise during clock high is stop.
// - writes carry one or two bytes; reads return exactly one byte.
// - first written byte always loads the address pointer.
// - read without pointer write returns register at retained pointer.
// - send byte, write byte, receive byte and read byte supported.
// - repeated start begins a new transfer without going idle.
// - send byte acks address and command, command becomes pointer.
// - repeated start after send byte gives one-byte read at new pointer.
// - write byte acks each byte and writes data at the pointer only when it is the core low or high limit.
// - direction fixed by the address byte until next start.
// - core and supply readings reset to zero, show latest average.
// - core reading outside a limit sets status bit and alert.
// - core low limit resets 0x00, high limit resets 0xFF.
// - each reading averages 16 conversions, about 11.38 ms.
// - extended register read freezes voltage readings until they are read.
// - clock held low past timeout releases the bus; can be disabled.
`timescale 1ns/1ps
`include "smm_consts.svh"

module smm_port #(
   parameter int CONV_CYCLES = `SMM_CONV_CYC,
   parameter int TOUT_CYCLES = `SMM_TOUT_CYC
) (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   input  wire logic       i_timeout_en,
   input  wire logic [9:0] i_core_code,
   input  wire logic [9:0] i_supply_code,
   output logic            o_sda_out,
   output logic            o_sda_oe,
   output logic            o_out_of_limit_alert_n
);

   // ****************************************
   // declarations
   // ****************************************
   smm_pkg::smm_state_e state_reg;
   logic        scl_s;
   logic        sda_s;
   logic        scl_d_reg;
   logic        sda_d_reg;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic [2:0]  bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  rx_byte;
   logic        byte_done;
   logic        addr_hit;
   logic        rw_reg;
   logic        ack_seen_reg;
   logic [1:0]  byte_idx_reg;
   logic [7:0]  ptr_reg;
   logic [7:0]  tx_reg;
   logic [7:0]  rd_val;
   logic        rd_fire;
   logic        wr_fire;
   logic        sda_oe_reg;
   logic [19:0] low_cnt_reg;
   logic        tout_hit;
   logic [19:0] conv_cnt_reg;
   logic        conv_tick;
   logic [3:0]  smp_cnt_reg;
   logic [13:0] core_acc_reg;
   logic [13:0] sup_acc_reg;
   logic [13:0] core_acc_next;
   logic [13:0] sup_acc_next;
   logic        avg_done_reg;
   logic [9:0]  core_avg_reg;
   logic [9:0]  sup_avg_reg;
   logic [9:0]  core_rd_reg;
   logic [9:0]  sup_rd_reg;
   logic        core_lock_reg;
   logic        sup_lock_reg;
   logic [7:0]  core_lo_reg;
   logic [7:0]  core_hi_reg;
   logic [1:0]  status_reg;
   logic        alert_n_reg;

   // ****************************************
   // pin synchronisers and bus events
   // ****************************************
   smm_sync u_scl_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_async   (i_scl),
      .o_sync    (scl_s)
   );

   smm_sync u_sda_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_async   (i_sda),
      .o_sync    (sda_s)
   );

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_d_reg;
   assign scl_fall  = ~scl_s & scl_d_reg;
   assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   assign rx_byte   = {shift_reg[6:0], sda_s};
   assign byte_done = scl_rise && (bit_cnt_reg == 3'h7);
   assign addr_hit  = (rx_byte[7:1] == `SMM_ADDR7);
   assign rd_fire   = (state_reg == smm_pkg::ST_ACK_A) && scl_fall && ack_seen_reg && rw_reg;
   assign wr_fire   = (state_reg == smm_pkg::ST_WR) && byte_done && (byte_idx_reg == 2'h1);

   // ****************************************
   // register read decode
   // ****************************************
   function automatic logic [7:0] rd_mux(input logic [7:0] ofs);
      logic [7:0] val;
      val = 8'h00;
      if (ofs == `SMM_OFS_CORE_RD) begin
         val = core_rd_reg[9:2];
      end else if (ofs == `SMM_OFS_SUP_RD) begin
         val = sup_rd_reg[9:2];
      end else if (ofs == `SMM_OFS_STATUS) begin
         val = {6'h00, status_reg};
      end else if (ofs == `SMM_OFS_CORE_LO) begin
         val = core_lo_reg;
      end else if (ofs == `SMM_OFS_CORE_HI) begin
         val = core_hi_reg;
      end else if (ofs == `SMM_OFS_EXT_ONE) begin
         val = {4'h0, sup_rd_reg[1:0], core_rd_reg[1:0]};
      end
      return val;
   endfunction

   assign rd_val = rd_mux(ptr_reg);

   // ****************************************
   // clock low timeout
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || scl_s) begin
         low_cnt_reg <= 20'h00000;
      end else if (low_cnt_reg != 20'hFFFFF) begin
         low_cnt_reg <= low_cnt_reg + 20'h00001;
      end
   end

   assign tout_hit = i_timeout_en && (low_cnt_reg >= 20'(TOUT_CYCLES - 1));

   // ****************************************
   // transfer state machine
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || tout_hit) begin
         state_reg <= smm_pkg::ST_IDLE;
      end else if (start_det) begin
         state_reg <= smm_pkg::ST_ADDR;
      end else if (stop_det) begin
         state_reg <= smm_pkg::ST_IDLE;
      end else begin
         case (state_reg)
            smm_pkg::ST_ADDR: begin
               if (byte_done) begin
                  state_reg <= addr_hit ? smm_pkg::ST_ACK_A : smm_pkg::ST_IGN;
               end
            end
            smm_pkg::ST_ACK_A: begin
               if (scl_fall && ack_seen_reg) begin
                  state_reg <= rw_reg ? smm_pkg::ST_RD : smm_pkg::ST_WR;
               end
            end
            smm_pkg::ST_WR: begin
               if (byte_done) begin
                  state_reg <= (byte_idx_reg < 2'h2) ? smm_pkg::ST_ACK_W : smm_pkg::ST_IGN;
               end
            end
            smm_pkg::ST_ACK_W: begin
               if (scl_fall && ack_seen_reg) begin
                  state_reg <= smm_pkg::ST_WR;
               end
            end
            smm_pkg::ST_RD: begin
               if (byte_done) begin
                  state_reg <= smm_pkg::ST_ACK_R;
               end
            end
            smm_pkg::ST_ACK_R: begin
               if (scl_rise) begin
                  state_reg <= smm_pkg::ST_IGN;
               end
            end
            default: begin
               state_reg <= state_reg;
            end
         endcase
      end
   end

   // ****************************************
   // bit counter, shifter, acknowledge phase
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || start_det) begin
         bit_cnt_reg <= 3'h0;
         shift_reg   <= 8'h00;
      end else if (scl_rise && ((state_reg == smm_pkg::ST_ADDR) ||
                                (state_reg == smm_pkg::ST_WR) ||
                                (state_reg == smm_pkg::ST_RD))) begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         shift_reg   <= rx_byte;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         ack_seen_reg <= 1'b0;
      end else if ((state_reg == smm_pkg::ST_ACK_A) || (state_reg == smm_pkg::ST_ACK_W)) begin
         ack_seen_reg <= ack_seen_reg | scl_rise;
      end else begin
         ack_seen_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rw_reg <= 1'b0;
      end else if ((state_reg == smm_pkg::ST_ADDR) && byte_done && !start_det) begin
         rw_reg <= rx_byte[0];
      end
   end

   // ****************************************
   // pointer and write bytes
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || start_det) begin
         byte_idx_reg <= 2'h0;
      end else if ((state_reg == smm_pkg::ST_WR) && byte_done && (byte_idx_reg != 2'h3)) begin
         byte_idx_reg <= byte_idx_reg + 2'h1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         ptr_reg <= `SMM_RST_PTR;
      end else if ((state_reg == smm_pkg::ST_WR) && byte_done && (byte_idx_reg == 2'h0)) begin
         ptr_reg <= rx_byte;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         core_lo_reg <= `SMM_RST_CORE_LO;
         core_hi_reg <= `SMM_RST_CORE_HI;
      end else if (wr_fire && (ptr_reg == `SMM_OFS_CORE_LO)) begin
         core_lo_reg <= rx_byte;
      end else if (wr_fire && (ptr_reg == `SMM_OFS_CORE_HI)) begin
         core_hi_reg <= rx_byte;
      end
   end

   // ****************************************
   // transmit byte and data line drive
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         tx_reg <= 8'h00;
      end else if (rd_fire) begin
         tx_reg <= rd_val;
      end else if (scl_fall && (state_reg == smm_pkg::ST_RD)) begin
         tx_reg <= {tx_reg[6:0], 1'b0};
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst || tout_hit || start_det || stop_det) begin
         sda_oe_reg <= 1'b0;
      end else if (scl_fall) begin
         case (state_reg)
            smm_pkg::ST_ACK_A: begin
               sda_oe_reg <= ack_seen_reg ? (rw_reg && !rd_val[7]) : 1'b1;
            end
            smm_pkg::ST_ACK_W: begin
               sda_oe_reg <= !ack_seen_reg;
            end
            smm_pkg::ST_RD: begin
               sda_oe_reg <= !tx_reg[6];
            end
            default: begin
               sda_oe_reg <= 1'b0;
            end
         endcase
      end
   end

   assign o_sda_out = 1'b0;
   assign o_sda_oe  = sda_oe_reg;

   // ****************************************
   // conversion cadence and averaging
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || conv_tick) begin
         conv_cnt_reg <= 20'h00000;
      end else begin
         conv_cnt_reg <= conv_cnt_reg + 20'h00001;
      end
   end

   assign conv_tick     = (conv_cnt_reg == 20'(CONV_CYCLES - 1));
   assign core_acc_next = core_acc_reg + {4'h0, i_core_code};
   assign sup_acc_next  = sup_acc_reg + {4'h0, i_supply_code};

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         smp_cnt_reg  <= 4'h0;
         core_acc_reg <= 14'h0000;
         sup_acc_reg  <= 14'h0000;
         avg_done_reg <= 1'b0;
         core_avg_reg <= `SMM_RST_READING;
         sup_avg_reg  <= `SMM_RST_READING;
      end else begin
         avg_done_reg <= 1'b0;
         if (conv_tick) begin
            smp_cnt_reg <= smp_cnt_reg + 4'h1;
            if (smp_cnt_reg == 4'(`SMM_AVG_N - 1)) begin
               core_acc_reg <= 14'h0000;
               sup_acc_reg  <= 14'h0000;
               avg_done_reg <= 1'b1;
               core_avg_reg <= core_acc_next[13:4];
               sup_avg_reg  <= sup_acc_next[13:4];
            end else begin
               core_acc_reg <= core_acc_next;
               sup_acc_reg  <= sup_acc_next;
            end
         end
      end
   end

   // ****************************************
   // readings with extended resolution lock
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         core_lock_reg <= 1'b0;
         sup_lock_reg  <= 1'b0;
      end else if (rd_fire && ((ptr_reg == `SMM_OFS_EXT_ONE) || (ptr_reg == `SMM_OFS_EXT_TWO))) begin
         core_lock_reg <= 1'b1;
         sup_lock_reg  <= 1'b1;
      end else if (rd_fire && (ptr_reg == `SMM_OFS_CORE_RD)) begin
         core_lock_reg <= 1'b0;
      end else if (rd_fire && (ptr_reg == `SMM_OFS_SUP_RD)) begin
         sup_lock_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         core_rd_reg <= `SMM_RST_READING;
         sup_rd_reg  <= `SMM_RST_READING;
      end else if (avg_done_reg) begin
         if (!core_lock_reg) begin
            core_rd_reg <= core_avg_reg;
         end
         if (!sup_lock_reg) begin
            sup_rd_reg <= sup_avg_reg;
         end
      end
   end

   // ****************************************
   // limit status, cleared by reading, set wins
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         status_reg <= 2'h0;
      end else begin
         status_reg[`SMM_STS_LOW_BIT] <=
            (status_reg[`SMM_STS_LOW_BIT] && !(rd_fire && (ptr_reg == `SMM_OFS_STATUS))) ||
            (avg_done_reg && (core_avg_reg[9:2] < core_lo_reg));
         status_reg[`SMM_STS_HIGH_BIT] <=
            (status_reg[`SMM_STS_HIGH_BIT] && !(rd_fire && (ptr_reg == `SMM_OFS_STATUS))) ||
            (avg_done_reg && (core_avg_reg[9:2] > core_hi_reg));
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         alert_n_reg <= 1'b1;
      end else begin
         alert_n_reg <= !(|status_reg);
      end
   end

   assign o_out_of_limit_alert_n = alert_n_reg;

   // ****************************************
   // assertions and covers
   // ****************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   a_foreign_addr: assert property (
      (state_reg == smm_pkg::ST_ADDR) && byte_done && !addr_hit && !start_det && !stop_det
      |=> (state_reg == smm_pkg::ST_IGN) && !sda_oe_reg)
      else $error("foreign address not ignored");
   a_own_addr_ack: assert property (
      (state_reg == smm_pkg::ST_ADDR) && byte_done && addr_hit && !start_det && !stop_det
      && !tout_hit |=> (state_reg == smm_pkg::ST_ACK_A) && (rw_reg == $past(sda_s)))
      else $error("own address not taken");
   a_oe_clock_low: assert property (
      $changed(sda_oe_reg) |-> !$past(scl_s) || $past(start_det || stop_det || tout_hit))
      else $error("data line changed while clock high");
   a_one_read: assert property (
      (state_reg == smm_pkg::ST_ACK_R) && scl_rise && !start_det && !stop_det && !tout_hit
      |=> (state_reg == smm_pkg::ST_IGN) ##1 !sda_oe_reg)
      else $error("more than one byte read");
   a_ptr_load: assert property (
      (state_reg == smm_pkg::ST_WR) && byte_done && (byte_idx_reg == 2'h0) && !start_det
      && !stop_det && !tout_hit |=> (ptr_reg == $past(rx_byte)))
      else $error("pointer not loaded");
   a_read_ptr: assert property (
      rd_fire |=> (tx_reg == $past(rd_val)) && sda_oe_reg == !tx_reg[7])
      else $error("read byte not from pointer");
   a_limit_write: assert property (
      wr_fire && (ptr_reg == `SMM_OFS_CORE_HI) && !start_det && !stop_det
      |=> (core_hi_reg == $past(rx_byte)))
      else $error("limit write lost");
   a_restart: assert property (
      start_det && !tout_hit |=> (state_reg == smm_pkg::ST_ADDR) && (bit_cnt_reg == 3'h0))
      else $error("repeated start not taken");
   a_lock_hold: assert property (
      core_lock_reg && avg_done_reg |=> $stable(core_rd_reg))
      else $error("locked reading changed");
   a_avg_update: assert property (
      avg_done_reg && !core_lock_reg |=> (core_rd_reg == $past(core_avg_reg)))
      else $error("reading not updated");
   a_limit_flag: assert property (
      avg_done_reg && (core_avg_reg[9:2] > core_hi_reg)
      |=> status_reg[`SMM_STS_HIGH_BIT] ##1 !o_out_of_limit_alert_n)
      else $error("high limit not flagged");
   a_timeout_rel: assert property (
      tout_hit |=> !sda_oe_reg && (state_reg == smm_pkg::ST_IDLE))
      else $error("bus not released on timeout");
   a_reset_vals: assert property (
      $fell(i_rst) |-> (core_lo_reg == `SMM_RST_CORE_LO) && (core_hi_reg == `SMM_RST_CORE_HI)
      && (core_rd_reg == `SMM_RST_READING))
      else $error("bad reset values");

   c_write_byte: cover property (wr_fire);
   c_read_byte: cover property (rd_fire ##[1:1000] (state_reg == smm_pkg::ST_ACK_R));
   c_ext_lock: cover property (core_lock_reg && avg_done_reg);
   c_timeout: cover property (tout_hit);

endmodule

// File: smm_consts.svh
// constants of the serial management bus monitor port
`ifndef SMM_CONSTS_SVH
`define SMM_CONSTS_SVH

// ****************************************
// bus address
// ****************************************
`define SMM_ADDR7        7'h2E
`define SMM_ADDR_WR      8'h5C

// ****************************************
// register offsets
// ****************************************
`define SMM_OFS_CORE_RD  8'h21
`define SMM_OFS_SUP_RD   8'h22
`define SMM_OFS_STATUS   8'h41
`define SMM_OFS_CORE_LO  8'h46
`define SMM_OFS_CORE_HI  8'h47
`define SMM_OFS_EXT_ONE  8'h76
`define SMM_OFS_EXT_TWO  8'h77

// ****************************************
// reset values and field positions
// ****************************************
`define SMM_RST_READING  10'h000
`define SMM_RST_CORE_LO  8'h00
`define SMM_RST_CORE_HI  8'hFF
`define SMM_RST_PTR      8'h00
`define SMM_STS_LOW_BIT  0
`define SMM_STS_HIGH_BIT 1

// ****************************************
// timing
// ****************************************
`define SMM_CLK_MHZ      20
`define SMM_AVG_N        16
`define SMM_CONV_US      711
`define SMM_CONV_CYC     (`SMM_CONV_US * `SMM_CLK_MHZ)
`define SMM_TOUT_MS      25
`define SMM_TOUT_CYC     (`SMM_TOUT_MS * 1000 * `SMM_CLK_MHZ)

`endif

// File: smm_pkg.sv
// types of the serial management bus monitor port
package smm_pkg;

   // ****************************************
   // slave port states, gray along the usual path
   // ****************************************
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_ADDR  = 3'h1,
      ST_ACK_A = 3'h3,
      ST_WR    = 3'h2,
      ST_ACK_W = 3'h6,
      ST_RD    = 3'h7,
      ST_ACK_R = 3'h5,
      ST_IGN   = 3'h4
   } smm_state_e;

endpackage

// File: smm_sync.sv
// two flip-flop synchroniser for a pin input
`timescale 1ns/1ps

module smm_sync (
   input  wire logic i_sys_clk,
   input  wire logic i_rst,
   input  wire logic i_async,
   output logic      o_sync
);

   logic meta_reg;
   logic sync_reg;

   // ****************************************
   // both stages idle high like the bus
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule

// File: smm_master_model.sv
// host master model driving the serial management bus
`timescale 1ns/1ps
`include "smm_consts.svh"

module smm_master_model (
   input  wire logic i_sys_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask

   // one clock pulse, 6 low and 2 high; data moves only while clock low
   task automatic bit_io(input logic v, output logic s);
      o_sda_low <= !v;
      tick(5);
      o_scl <= 1'b1;
      tick(2);
      s = i_sda;
      o_scl <= 1'b0;
      tick(1);
   endtask

   // start from idle, or repeated start after an acknowledge slot
   task automatic start;
      o_sda_low <= 1'b0;
      tick(3);
      o_scl <= 1'b1;
      tick(3);
      o_sda_low <= 1'b1;
      tick(3);
      o_scl <= 1'b0;
      tick(1);
   endtask

   task automatic stop;
      o_sda_low <= 1'b1;
      tick(3);
      o_scl <= 1'b1;
      tick(3);
      o_sda_low <= 1'b0;
      tick(4);
   endtask

   // eight bits msb first, then the acknowledge slot released
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ak);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'b1, ak);
   endtask

   task automatic write(input logic [7:0] a, input logic [23:0] b, input int n,
                        output logic ak);
      logic [7:0] q;
      start();
      xfer(a, q, ak);
      for (int k = 0; k < n; k++) xfer(b[23-8*k -: 8], q, ak);
      stop();
   endtask

   task automatic read(input logic ptr, input logic [7:0] ofs, output logic [7:0] q);
      logic ak;
      start();
      if (ptr) begin
         xfer(`SMM_ADDR_WR, q, ak);
         xfer(ofs, q, ak);
         start();
      end
      xfer({`SMM_ADDR7, 1'b1}, q, ak);
      xfer(8'hFF, q, ak);
      stop();
   endtask
endmodule

// File: smbus_monitor_register_port_tb_top.sv
// testbench of the serial management bus monitor port
`timescale 1ns/1ps
`include "smm_consts.svh"

module smbus_monitor_register_port_tb_top;
   localparam int CONV = 20;
   localparam int TOUT = 200;
   typedef struct packed {
      logic       wr;
      logic [7:0] ofs;
      logic [7:0] dat;
      logic [7:0] exp;
   } smm_row_s;

   logic       i_sys_clk  = 1'b0;
   logic       i_rst      = 1'b1;
   logic       tout_en    = 1'b0;
   logic [9:0] core_code  = 10'h000;
   logic [9:0] sup_code   = 10'h000;
   logic       scl;
   logic       mst_low;
   logic       sda_oe;
   logic       sda_out;
   logic       alert_n;
   wire        sda        = !(sda_oe || mst_low);
   int         num_errors = 0;
   int         n_tests    = 0;
   logic [7:0] q;
   logic       ak;
   smm_row_s   rows [9]   = '{
      '{1'b0, 8'h46, 8'h00, 8'h00},
      '{1'b0, 8'h47, 8'h00, 8'hFF},
      '{1'b0, 8'h21, 8'h00, 8'h00},
      '{1'b0, 8'h22, 8'h00, 8'h00},
      '{1'b0, 8'h41, 8'h00, 8'h00},
      '{1'b1, 8'h21, 8'h55, 8'h00},
      '{1'b1, 8'h47, 8'h80, 8'h80},
      '{1'b1, 8'h46, 8'h40, 8'h40},
      '{1'b0, 8'h10, 8'h00, 8'h00}};

   smm_port #(
      .CONV_CYCLES (CONV),
      .TOUT_CYCLES (TOUT)
   ) u_dut (
      .i_sys_clk              (i_sys_clk),
      .i_rst                  (i_rst),
      .i_scl                  (scl),
      .i_sda                  (sda),
      .i_timeout_en           (tout_en),
      .i_core_code            (core_code),
      .i_supply_code          (sup_code),
      .o_sda_out              (sda_out),
      .o_sda_oe               (sda_oe),
      .o_out_of_limit_alert_n (alert_n)
   );

   smm_master_model u_mst (
      .i_sys_clk (i_sys_clk),
      .i_sda     (sda),
      .o_scl     (scl),
      .o_sda_low (mst_low)
   );

   initial begin
      forever #25 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic results;
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask

   initial begin
      waitc(100000);
      num_errors++;
      results();
   end

   initial begin
      waitc(5);
      chk("alert in reset", 8'h01, {7'h0, alert_n});
      chk("data out", 8'h00, {7'h0, sda_out});
      i_rst <= 1'b0;
      waitc(6);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            u_mst.write(`SMM_ADDR_WR, {rows[i].ofs, rows[i].dat, 8'h00}, 2, ak);
            chk("write ack", 8'h00, {7'h0, ak});
         end
         u_mst.read(1'b1, rows[i].ofs, q);
         chk("row read", rows[i].exp, q);
      end
      $display("table done");
      u_mst.write(8'h5E, 24'h0, 0, ak);
      chk("foreign ack", 8'h01, {7'h0, ak});
      u_mst.write(`SMM_ADDR_WR, 24'h463F11, 3, ak);
      chk("third byte ack", 8'h01, {7'h0, ak});
      u_mst.read(1'b1, 8'h46, q);
      chk("low limit", 8'h3F, q);
      $display("refusals done");
      core_code <= 10'h204;
      sup_code <= 10'h0C6;
      waitc(800);
      u_mst.read(1'b1, 8'h41, q);
      chk("status both", 8'h03, q);
      waitc(400);
      chk("alert", 8'h00, {7'h0, alert_n});
      u_mst.read(1'b1, 8'h41, q);
      chk("status high", 8'h02, q);
      u_mst.read(1'b1, 8'h21, q);
      chk("core reading", 8'h81, q);
      $display("averaging done");
      u_mst.read(1'b1, 8'h76, q);
      chk("extended", 8'h08, q);
      core_code <= 10'h100;
      waitc(800);
      u_mst.read(1'b1, 8'h21, q);
      chk("locked core", 8'h81, q);
      waitc(800);
      u_mst.read(1'b0, 8'h00, q);
      chk("receive byte", 8'h40, q);
      u_mst.write(`SMM_ADDR_WR, 24'h220000, 1, ak);
      u_mst.read(1'b0, 8'h00, q);
      chk("send then receive", 8'h31, q);
      $display("lock done");
      u_mst.start();
      q = `SMM_ADDR_WR;
      for (int i = 7; i >= 0; i--) u_mst.bit_io(q[i], ak);
      waitc(250);
      chk("ack held", 8'h01, {7'h0, sda_oe});
      tout_en <= 1'b1;
      waitc(250);
      chk("timeout release", 8'h00, {7'h0, sda_oe});
      u_mst.stop();
      $display("timeout done");
      results();
   end
endmodule
